// [rtl/mult_pkg.sv]
// Constants for the single-cycle 8x8 multiplier block.
// Assumes a register port with one-cycle read latency.
package mult_pkg;
  localparam int unsigned OPERAND_WIDTH = 8;
  localparam int unsigned PRODUCT_WIDTH = 16;
  localparam int unsigned ADDR_WIDTH    = 4;
  localparam logic [3:0] OFFSET_PRODUCT_LOW  = 4'h0;
  localparam logic [3:0] OFFSET_PRODUCT_HIGH = 4'h1;
  localparam logic [3:0] OFFSET_WORKING      = 4'h2;
  localparam logic [3:0] OFFSET_STATUS       = 4'h3;
  localparam logic [7:0] RESET_PRODUCT_LOW   = 8'h00;
  localparam logic [7:0] RESET_PRODUCT_HIGH  = 8'h00;
  localparam logic [7:0] RESET_WORKING       = 8'h00;
  localparam logic [7:0] RESET_STATUS        = 8'h00;
  localparam int unsigned MULTIPLY_CYCLES    = 1;
endpackage

// [rtl/product_array.sv]
// Combinational unsigned array multiplier, partial products in a generate loop.
// Assumes the caller registers the result.
`timescale 1ns/1ns
`default_nettype none
module product_array #(
  parameter int unsigned WIDTH = 8
) (
  input  wire logic [WIDTH-1:0]   factor_a,
  input  wire logic [WIDTH-1:0]   factor_b,
  output logic      [2*WIDTH-1:0] product
);
  logic [2*WIDTH-1:0] partial [WIDTH];
  logic [2*WIDTH-1:0] running [WIDTH+1];

  assign running[0] = '0;
  for (genvar i = 0; i < WIDTH; i++)
  begin : g_row
    assign partial[i] = factor_b[i] ? ({{WIDTH{1'b0}}, factor_a} << i) : '0;
    assign running[i+1] = running[i] + partial[i];
  end
  assign product = running[WIDTH];
endmodule
`default_nettype wire

// [rtl/hw_multiplier.sv]
// ALU multiplier with product register pair, working register and status flags.
// Assumes a decoder pulses mul_go with the file operand; register port is synchronous.
// Overview of operation
// RULE_01: Unsigned 8x8 multiply finishes in one instruction cycle, never stalls.
// RULE_02: Upper product byte goes to high byte, lower to low byte.
// RULE_03: Multiply leaves carry, digit carry, zero and overflow flags untouched.
// RULE_04: One multiply instruction: working register times addressed file operand.
// RULE_05: Software forms signed products by subtracting operands from the high byte.
// RULE_06: Software builds 16x16 products from four weighted 8x8 partial products.
// RULE_07: Product bytes hold until next multiply or a software write; readable.
`timescale 1ns/1ns
`default_nettype none
module hw_multiplier
  import mult_pkg::*;
(
  input  wire logic                                sys_clk,
  input  wire logic                                rst_n,
  input  wire logic                                mul_go,
  input  wire logic [mult_pkg::OPERAND_WIDTH-1:0]  file_operand,
  input  wire logic                                flags_load,
  input  wire logic [7:0]                          flags_in,
  input  wire logic [mult_pkg::ADDR_WIDTH-1:0]     reg_addr,
  input  wire logic [7:0]                          reg_wdata,
  input  wire logic                                reg_wr,
  input  wire logic                                reg_rd,
  output logic      [7:0]                          reg_rdata,
  output logic      [mult_pkg::OPERAND_WIDTH-1:0]  product_high_byte,
  output logic      [mult_pkg::OPERAND_WIDTH-1:0]  product_low_byte,
  output logic      [7:0]                          alu_status_register,
  output logic                                     mul_done
);
  import mult_pkg::*;

  typedef struct packed {
    logic [7:0] prod_high;
    logic [7:0] prod_low;
    logic [7:0] working;
    logic [7:0] status;
    logic [7:0] rdata;
    logic       done;
  } state_s;

  state_s state_reg;
  state_s state_next;
  logic [PRODUCT_WIDTH-1:0] product_wire;

  // One-cycle combinational product
  product_array #(
    .WIDTH (OPERAND_WIDTH)
  ) u_array (
    .factor_a (state_reg.working),
    .factor_b (file_operand),
    .product  (product_wire)
  );

  always_comb
  begin
    state_next = state_reg;
    state_next.done = mul_go; // [RULE_01]
    state_next.rdata = 8'h00;
    if (reg_wr)
    begin
      case (reg_addr)
        OFFSET_PRODUCT_LOW:  state_next.prod_low  = reg_wdata; // [RULE_07]
        OFFSET_PRODUCT_HIGH: state_next.prod_high = reg_wdata; // [RULE_07]
        OFFSET_WORKING:      state_next.working   = reg_wdata;
        OFFSET_STATUS:       state_next.status    = reg_wdata;
        default:             state_next.rdata     = 8'h00;
      endcase
    end
    if (flags_load)
    begin
      state_next.status = flags_in;
    end
    // Multiply wins over a same-cycle software write
    if (mul_go)
    begin
      state_next.prod_high = product_wire[15:8]; // [RULE_02] [RULE_04]
      state_next.prod_low  = product_wire[7:0];  // [RULE_02]
      state_next.status    = state_reg.status;   // [RULE_03]
    end
    if (reg_rd)
    begin
      case (reg_addr)
        OFFSET_PRODUCT_LOW:  state_next.rdata = state_reg.prod_low; // [RULE_07]
        OFFSET_PRODUCT_HIGH: state_next.rdata = state_reg.prod_high;
        OFFSET_WORKING:      state_next.rdata = state_reg.working;
        OFFSET_STATUS:       state_next.rdata = state_reg.status;
        default:             state_next.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= '{prod_high: RESET_PRODUCT_HIGH, prod_low: RESET_PRODUCT_LOW,
                     working: RESET_WORKING, status: RESET_STATUS,
                     rdata: 8'h00, done: 1'b0};
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign reg_rdata           = state_reg.rdata;
  assign product_high_byte   = state_reg.prod_high;
  assign product_low_byte    = state_reg.prod_low;
  assign alu_status_register = state_reg.status;
  assign mul_done            = state_reg.done;

  // Checks
  localparam int MUL_LATENCY = int'(MULTIPLY_CYCLES);
  logic sel_low;
  logic sel_high;
  logic sel_working;
  logic sel_status;
  logic sel_mapped;

  always_comb
  begin
    sel_low     = (reg_addr == OFFSET_PRODUCT_LOW);
    sel_high    = (reg_addr == OFFSET_PRODUCT_HIGH);
    sel_working = (reg_addr == OFFSET_WORKING);
    sel_status  = (reg_addr == OFFSET_STATUS);
    sel_mapped  = sel_low | sel_high | sel_working | sel_status;
  end

  single_cycle_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE_01]
    mul_go |=> mul_done)
    else $error("multiply did not finish in one cycle");
  product_value_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE_02]
    mul_go |=> {product_high_byte, product_low_byte} ==
      16'($past(state_reg.working)) * 16'($past(file_operand)))
    else $error("product wrong");
  flags_kept_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE_03]
    (mul_go && !flags_load) |=> $stable(alu_status_register))
    else $error("multiply changed flags");
  operand_source_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE_04]
    (mul_go && file_operand == 8'h01) |=> product_low_byte == $past(state_reg.working))
    else $error("working register not used as operand");
  product_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE_07]
    (!mul_go && !reg_wr) |=> $stable({product_high_byte, product_low_byte}))
    else $error("product changed without cause");
  high_write_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE_07]
    (reg_wr && !mul_go && reg_addr == OFFSET_PRODUCT_HIGH) |=>
      product_high_byte == $past(reg_wdata))
    else $error("high byte write lost");
  low_read_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE_07]
    (reg_rd && reg_addr == OFFSET_PRODUCT_LOW) |=> reg_rdata == $past(product_low_byte))
    else $error("low byte read wrong");
  done_pulse_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE_01]
    !mul_go |=> !mul_done)
    else $error("done without multiply");

  // Multiply path
  latency_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE_01]
    mul_go |-> ##[1:MUL_LATENCY] mul_done)
    else $error("multiply latency wrong");
  back_to_back_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE_01]
    (mul_go ##1 mul_go) |=> mul_done)
    else $error("back to back multiply stalled");
  mul_flags_any_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE_03]
    mul_go |=> $stable(alu_status_register))
    else $error("multiply cycle changed flags");
  high_value_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE_02]
    mul_go |=>
      product_high_byte == 8'((16'($past(state_reg.working)) *
                               16'($past(file_operand))) >> 8))
    else $error("high product byte wrong");
  low_value_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE_02]
    mul_go |=>
      product_low_byte == 8'(16'($past(state_reg.working)) *
                             16'($past(file_operand))))
    else $error("low product byte wrong");
  zero_factor_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE_02]
    (mul_go && (file_operand == 8'h00 || state_reg.working == 8'h00)) |=>
      {product_high_byte, product_low_byte} == 16'h0000)
    else $error("zero factor gave nonzero product");
  working_kept_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE_04]
    (mul_go && !(reg_wr && sel_working)) |=> $stable(state_reg.working))
    else $error("multiply changed working register");
  working_write_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE_04]
    (reg_wr && sel_working) |=> state_reg.working == $past(reg_wdata))
    else $error("working register write lost");
  flags_update_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE_03]
    (flags_load && !mul_go) |=> alu_status_register == $past(flags_in))
    else $error("flag update lost");
  flags_write_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE_03]
    (reg_wr && sel_status && !mul_go && !flags_load) |=>
      alu_status_register == $past(reg_wdata))
    else $error("status write lost");
  status_kept_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE_03]
    (!mul_go && !flags_load && !(reg_wr && sel_status)) |=>
      $stable(alu_status_register))
    else $error("flags changed without cause");

  // Register port
  low_write_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE_07]
    (reg_wr && !mul_go && sel_low) |=> product_low_byte == $past(reg_wdata))
    else $error("low byte write lost");
  high_kept_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE_07]
    (!mul_go && !(reg_wr && sel_high)) |=>
      $stable(product_high_byte))
    else $error("high byte changed without cause");
  low_kept_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE_07]
    (!mul_go && !(reg_wr && sel_low)) |=>
      $stable(product_low_byte))
    else $error("low byte changed without cause");
  high_read_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE_07]
    (reg_rd && sel_high) |=> reg_rdata == $past(product_high_byte))
    else $error("high byte read wrong");
  working_read_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE_04]
    (reg_rd && sel_working) |=> reg_rdata == $past(state_reg.working))
    else $error("working register read wrong");
  status_read_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE_03]
    (reg_rd && sel_status) |=> reg_rdata == $past(alu_status_register))
    else $error("status read wrong");
  unmapped_read_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE_07]
    (reg_rd && !sel_mapped) |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  read_idle_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE_07]
    !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data without read");
endmodule
`default_nettype wire

// [sim/tb_top.sv]
// Bench for hw_multiplier: random and corner multiplies, register reads and writes.
// Assumes mult_pkg, product_array and hw_multiplier are compiled first.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import mult_pkg::*;
  logic        sys_clk, rst_n, mul_go, flags_load, reg_wr, reg_rd, mul_done;
  logic [7:0]  file_operand, flags_in, reg_wdata, reg_rdata, prod_hi, prod_lo, status;
  logic [7:0]  a, b, f;
  logic [3:0]  reg_addr;
  logic [15:0] p;
  logic [7:0]  h, l;
  logic [15:0] x, y;
  logic [31:0] acc;
  int          errors, check_count;
  int          cycles = 0;
  hw_multiplier DUT (.sys_clk(sys_clk), .rst_n(rst_n), .mul_go(mul_go),
    .file_operand(file_operand), .flags_load(flags_load), .flags_in(flags_in),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .product_high_byte(prod_hi), .product_low_byte(prod_lo),
    .alu_status_register(status), .mul_done(mul_done));
  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // One bus cycle: every input driven once per edge
  task automatic cyc(input logic go, input logic [7:0] opnd, input logic wr, input logic rd,
                     input logic [3:0] adr, input logic [7:0] wd, input logic fl);
    @(posedge sys_clk);
    mul_go       <= go;
    file_operand <= opnd;
    reg_wr       <= wr;
    reg_rd       <= rd;
    reg_addr     <= adr;
    reg_wdata    <= wd;
    flags_in     <= wd;
    flags_load   <= fl;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic logic [15:0] model(input logic [7:0] x, input logic [7:0] y);
    return {8'h00, x} * {8'h00, y};
  endfunction
  function automatic logic [15:0] smodel(input logic [7:0] x, input logic [7:0] y);
    return {{8{x[7]}}, x} * {{8{y[7]}}, y};
  endfunction
  function automatic logic [31:0] wmodel(input logic [15:0] x, input logic [15:0] y);
    return {16'h0000, x} * {16'h0000, y};
  endfunction
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR t=%0t wide got %h exp %h", $time, got, exp);
    end
  endtask
  // Load working register, multiply, let the product settle
  task automatic mul_op(input logic [7:0] x, input logic [7:0] y);
    cyc(1'b0, 8'h00, 1'b1, 1'b0, OFFSET_WORKING, x, 1'b0);
    cyc(1'b1, y, 1'b0, 1'b0, 4'h0, 8'h00, 1'b0);
    cyc(1'b0, 8'h00, 1'b0, 1'b0, 4'h0, 8'h00, 1'b0);
    #1;
  endtask
  task automatic rd_val(input logic [3:0] adr, output logic [7:0] v);
    cyc(1'b0, 8'h00, 1'b0, 1'b1, adr, 8'h00, 1'b0);
    cyc(1'b0, 8'h00, 1'b0, 1'b0, 4'h0, 8'h00, 1'b0);
    #1 v = reg_rdata;
  endtask
  task automatic rd_chk(input logic [3:0] adr, input logic [7:0] exp);
    cyc(1'b0, 8'h00, 1'b0, 1'b1, adr, 8'h00, 1'b0);
    cyc(1'b0, 8'h00, 1'b0, 1'b0, 4'h0, 8'h00, 1'b0);
    #1 chk({8'h00, reg_rdata}, {8'h00, exp});
  endtask
  task automatic report_and_stop;
    $display("errors=%0d checks=%0d", errors, check_count);
    if (errors == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Timeout
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles > 2000)
    begin
      errors++;
      report_and_stop();
    end
  end
  initial
  begin
    {mul_go, flags_load, reg_wr, reg_rd} = 4'h0;
    file_operand = 8'h00;
    flags_in = 8'h00;
    reg_wdata = 8'h00;
    reg_addr = 4'h0;
    rst_n = 1'b0;
    errors = 0;
    check_count = 0;
    void'($urandom(70613));
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    #1 chk({prod_hi, prod_lo}, 16'h0000);
    chk({7'h00, mul_done, reg_rdata}, 16'h0000);
    for (int i = 0; i < 40; i++)
    begin
      a = (i == 0) ? 8'hff : 8'($urandom);
      b = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($urandom);
      f = 8'($urandom);
      p = model(a, b);
      cyc(1'b0, 8'h00, 1'b1, 1'b0, OFFSET_WORKING, a, 1'b0);
      cyc(1'b0, 8'h00, 1'b0, 1'b0, 4'h0, f, 1'b1);
      cyc(1'b1, b, 1'b0, 1'b0, 4'h0, f, i[0]);
      cyc(1'b0, 8'h00, 1'b0, 1'b0, 4'h0, 8'h00, 1'b0);
      #1 chk({7'h00, mul_done, status}, {8'h01, f});
      chk({prod_hi, prod_lo}, p);
      rd_chk(OFFSET_PRODUCT_HIGH, p[15:8]);
      rd_chk(OFFSET_PRODUCT_LOW, p[7:0]);
    end
    cyc(1'b0, 8'h00, 1'b1, 1'b0, OFFSET_PRODUCT_LOW, 8'h5a, 1'b0);
    rd_chk(OFFSET_PRODUCT_LOW, 8'h5a);
    rd_chk(OFFSET_PRODUCT_HIGH, p[15:8]);
    rd_chk(OFFSET_STATUS, f);
    rd_chk(4'hf, 8'h00);
    // Signed product by software correction of the high byte
    for (int i = 0; i < 8; i++)
    begin
      a = (i == 0) ? 8'h80 : 8'($urandom);
      b = (i == 0) ? 8'h80 : (i == 1) ? 8'hff : 8'($urandom);
      mul_op(a, b);
      rd_val(OFFSET_PRODUCT_HIGH, h);
      if (b[7])
        h = h - a;
      if (a[7])
        h = h - b;
      cyc(1'b0, 8'h00, 1'b1, 1'b0, OFFSET_PRODUCT_HIGH, h, 1'b0);
      cyc(1'b0, 8'h00, 1'b0, 1'b0, 4'h0, 8'h00, 1'b0);
      #1 chk({prod_hi, prod_lo}, smodel(a, b));
    end
    // Wide product from four weighted partial products
    for (int i = 0; i < 6; i++)
    begin
      x = (i == 0) ? 16'hffff : 16'($urandom);
      y = (i == 0) ? 16'hffff : 16'($urandom);
      acc = 32'h0000_0000;
      for (int k = 0; k < 4; k++)
      begin
        mul_op(k[0] ? x[15:8] : x[7:0], k[1] ? y[15:8] : y[7:0]);
        rd_val(OFFSET_PRODUCT_HIGH, h);
        rd_val(OFFSET_PRODUCT_LOW, l);
        acc = acc + ({16'h0000, h, l} << (8 * (k[0] + k[1])));
      end
      chk32(acc, wmodel(x, y));
    end
    // Multiply beats a product write, back to back, flag strobe ignored
    cyc(1'b0, 8'h00, 1'b1, 1'b0, OFFSET_WORKING, 8'h9c, 1'b0);
    cyc(1'b1, 8'h37, 1'b1, 1'b0, OFFSET_PRODUCT_LOW, 8'h5a, 1'b0);
    cyc(1'b1, 8'h02, 1'b1, 1'b0, OFFSET_STATUS, 8'hc3, 1'b1);
    #1 chk({prod_hi, prod_lo}, model(8'h9c, 8'h37));
    cyc(1'b0, 8'h00, 1'b0, 1'b0, 4'h0, 8'h00, 1'b0);
    #1 chk({7'h00, mul_done, status}, {8'h01, f});
    chk({prod_hi, prod_lo}, model(8'h9c, 8'h02));
    rd_chk(OFFSET_STATUS, f);
    rd_chk(OFFSET_WORKING, 8'h9c);
    report_and_stop();
  end
endmodule
`default_nettype wire
